/* fcr_unit.sv */
// Fault classification and fault-record generation for the core
//
// Summary of operation
// - Trace subtype is one bit per mode; bit 0 reserved, bits 1-7 modes.
// - Events need their mode bit; fault needs process trace-enable too.
// - Any breakpoint condition, including mark instructions, is a breakpoint event.
// - Simultaneous trace events yield one fault with all their bits set.
// - Non-trace fault on a traced instruction is taken before the trace fault.
// - Interrupt during a traced instruction is serviced before the trace fault.
// - Prereturn trace precedes the return, so it beats faults and interrupts.
// - Trace faults record causing IP; prereturn leaves it undefined (zero).
// - Post-completion trace faults save next IP as saved IP; prereturn saves its own IP.
// - Post-completion trace faults change state; instruction not re-executed.
// - Prereturn trace changes no state; return executes after handler.
// - Type faults use type A, subtype 1 mismatch, 2 contents.
// - Descriptor type not suiting the operation raises type mismatch.
// - Undefined or inconsistent segment contents raise a contents fault.
// - Type fault records faulting IP only; state undefined, not restartable.
// - Virtual-memory faults use type 6, subtypes 1 segment, 2 dir, 3 page.
// - Segment descriptor valid flag zero raises invalid segment entry.
// - Page or directory entry valid flag zero raises matching fault.
// - Page/dir faults put upper 20 address bits in data word one 12-31.
// - Segment or large-segment page faults put index in word two 5-31.
// - VM faults save faulting IP; instruction cancelled or suspended.
// - Suspending an instruction sets resume flag; resume on return if set.
`timescale 1ns/1ns
`include "fcr_map.svh"

module fcr_unit (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                instr_done,
  input  wire logic [31:0]         instr_ip,
  input  wire logic [31:0]         next_ip,
  input  wire logic [7:0]          trace_mode,
  input  wire logic                trace_enable,
  input  wire logic                ev_instr,
  input  wire logic                ev_branch,
  input  wire logic                ev_call,
  input  wire logic                ev_ret,
  input  wire logic                ev_preret,
  input  wire logic                ev_super,
  input  wire logic                ev_brkpt,
  input  wire logic                type_mismatch,
  input  wire logic                type_contents,
  input  wire fcr_pkg::fcr_vm_t    vm,
  input  wire logic                irq_req,
  input  wire logic                handler_ret,
  output fcr_pkg::fcr_record_t     rec_r,
  output logic                     rec_valid_r,
  output logic                     irq_take_r,
  output logic                     resume_flag_r,
  output logic                     do_resume_r,
  output logic                     trace_pending_r
);

  // ==========================================================
  // Trace event collection
  logic [7:0]          ev_vec;
  logic [7:0]          ev_hit;
  logic [7:0]          post_bits_r;
  logic [31:0]         post_ip_r;
  logic [31:0]         post_next_r;
  logic                vm_any;
  logic                nontrace;
  fcr_pkg::fcr_state_t state_r;

  function automatic logic [7:0] fcr_sub_bit(input int b);
    logic [7:0] v;
    v = 8'h00;
    v[b] = 1'b1;
    return v;
  endfunction

  always_comb begin
    ev_vec = 8'h00;
    ev_vec[`FCR_TB_INSTR]  = ev_instr;
    ev_vec[`FCR_TB_BRANCH] = ev_branch;
    ev_vec[`FCR_TB_CALL]   = ev_call;
    ev_vec[`FCR_TB_RET]    = ev_ret;
    ev_vec[`FCR_TB_PRERET] = ev_preret;
    ev_vec[`FCR_TB_SUPER]  = ev_super;
    ev_vec[`FCR_TB_BRKPT]  = ev_brkpt;
  end

  assign ev_hit = (trace_enable && instr_done) ?
                  (ev_vec & trace_mode & `FCR_TRACE_MASK) : 8'h00;
  assign vm_any = vm.seg_invalid | vm.dir_invalid | vm.page_invalid;
  assign nontrace = instr_done & (vm_any | type_mismatch | type_contents);

  wire preret_hit = ev_hit[`FCR_TB_PRERET];
  wire [7:0] post_hit = ev_hit &
                        ~fcr_sub_bit(`FCR_TB_PRERET);

  // ==========================================================
  // Pending trace after completion; defer to faults and interrupts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r     <= fcr_pkg::FCR_IDLE;
      post_bits_r <= 8'h00;
      post_ip_r   <= `FCR_ZERO32;
      post_next_r <= `FCR_ZERO32;
    end else begin
      unique case (state_r)
        fcr_pkg::FCR_IDLE: begin
          // hold trace while the other fault goes
          if (!preret_hit && post_hit != 8'h00 &&
              (nontrace || irq_req)) begin
            state_r     <= fcr_pkg::FCR_TRACE_PD;
            post_bits_r <= post_hit;
            post_ip_r   <= instr_ip;
            post_next_r <= next_ip;
          end
        end
        fcr_pkg::FCR_TRACE_PD: begin
          if (!irq_req && !nontrace) begin
            state_r     <= fcr_pkg::FCR_IDLE;
            post_bits_r <= 8'h00;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Record selection, registered as one unit
  fcr_pkg::fcr_record_t rec_nxt;
  logic                 valid_nxt;
  logic                 irq_nxt;

  always_comb begin
    rec_nxt   = '0;
    valid_nxt = 1'b0;
    irq_nxt   = 1'b0;
    if (preret_hit) begin
      // prereturn first, before faults or interrupts
      rec_nxt.ftype   = `FCR_TYPE_TRACE;
      rec_nxt.subtype = ev_hit;
      // faulting IP undefined for prereturn, shown as zero
      rec_nxt.fault_ip = `FCR_ZERO32;
      rec_nxt.saved_ip = instr_ip;
      rec_nxt.state_change = 1'b0;
      rec_nxt.restartable  = 1'b1;
      valid_nxt = 1'b1;
    end else if (nontrace) begin
      if (vm_any) begin
        rec_nxt.ftype = `FCR_TYPE_VMEM;
        if (vm.seg_invalid)
          rec_nxt.subtype = `FCR_SUB_SEG;
        else if (vm.dir_invalid)
          rec_nxt.subtype = `FCR_SUB_DIR;
        else
          rec_nxt.subtype = `FCR_SUB_PAGE;
        if (!vm.seg_invalid)
          rec_nxt.data0 = {vm.addr[31:`FCR_PAGE_LSB],
                           {`FCR_PAGE_LSB{1'b0}}};
        if (vm.seg_invalid || (vm.page_invalid && vm.large_seg &&
                               !vm.dir_invalid))
          rec_nxt.data1 = {vm.seg_index, {`FCR_SEGIX_LSB{1'b0}}};
        // faulting IP saved, cancel or suspend
        rec_nxt.fault_ip     = instr_ip;
        rec_nxt.saved_ip     = instr_ip;
        rec_nxt.state_change = 1'b1;
        rec_nxt.restartable  = 1'b1;
        rec_nxt.resume       = vm.suspend;
      end else begin
        rec_nxt.ftype = `FCR_TYPE_TYPE;
        rec_nxt.subtype = type_mismatch ? `FCR_SUB_TMIS : `FCR_SUB_CONT;
        rec_nxt.fault_ip     = instr_ip;
        rec_nxt.state_change = 1'b1;
        rec_nxt.restartable  = 1'b0;
      end
      valid_nxt = 1'b1;
    end else if (irq_req) begin
      irq_nxt = 1'b1;
    end else if (state_r == fcr_pkg::FCR_TRACE_PD ||
                 post_hit != 8'h00) begin
      rec_nxt.ftype = `FCR_TYPE_TRACE;
      rec_nxt.subtype = (state_r == fcr_pkg::FCR_TRACE_PD) ?
                        post_bits_r : post_hit;
      rec_nxt.fault_ip = (state_r == fcr_pkg::FCR_TRACE_PD) ?
                         post_ip_r : instr_ip;
      rec_nxt.saved_ip = (state_r == fcr_pkg::FCR_TRACE_PD) ?
                         post_next_r : next_ip;
      rec_nxt.state_change = 1'b1;
      rec_nxt.restartable  = 1'b0;
      valid_nxt = 1'b1;
    end
  end

  // whole record in one registered cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rec_r       <= '0;
      rec_valid_r <= 1'b0;
      irq_take_r  <= 1'b0;
    end else begin
      rec_r       <= rec_nxt;
      rec_valid_r <= valid_nxt;
      irq_take_r  <= irq_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n)
      trace_pending_r <= 1'b0;
    else
      trace_pending_r <= (state_r == fcr_pkg::FCR_TRACE_PD) ||
                         (!preret_hit && post_hit != 8'h00 &&
                          (nontrace || irq_req));
  end

  // ==========================================================
  // Resume flag: set on suspend, checked at handler return
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      resume_flag_r <= 1'b0;
      do_resume_r   <= 1'b0;
    end else begin
      // set wins over the return-time clear
      do_resume_r <= handler_ret & resume_flag_r;
      if (valid_nxt && rec_nxt.resume)
        resume_flag_r <= 1'b1;
      else if (handler_ret)
        resume_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  // Fresh trace: nothing ahead of it, nothing deferred
  logic fresh_trace;
  assign fresh_trace = post_hit != 8'h00 && !preret_hit && !nontrace &&
                       !irq_req && state_r == fcr_pkg::FCR_IDLE;

  chk_preret_first: assert property (
    @(posedge clk) disable iff (!reset_n)
    preret_hit |=> rec_valid_r && rec_r.ftype == `FCR_TYPE_TRACE)
    else $error("prereturn not taken first");
  chk_preret_state: assert property (
    @(posedge clk) disable iff (!reset_n)
    preret_hit |=> !rec_r.state_change && rec_r.restartable)
    else $error("prereturn changed state");
  chk_trace_gate: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!trace_enable && state_r == fcr_pkg::FCR_IDLE && !nontrace)
      |=> !rec_valid_r)
    else $error("trace fault without enable");
  chk_trace_bit0: assert property (
    @(posedge clk) disable iff (!reset_n)
    (rec_valid_r && rec_r.ftype == `FCR_TYPE_TRACE)
      |-> !rec_r.subtype[0])
    else $error("reserved trace bit set");
  chk_trace_bits: assert property (
    @(posedge clk) disable iff (!reset_n)
    fresh_trace |=> rec_r.subtype ==
      ($past(ev_vec & trace_mode) & `FCR_TRACE_MASK))
    else $error("trace subtype bits wrong");
  chk_trace_ips: assert property (
    @(posedge clk) disable iff (!reset_n)
    fresh_trace |=> rec_valid_r && rec_r.fault_ip == $past(instr_ip) &&
      rec_r.saved_ip == $past(next_ip))
    else $error("trace record IPs wrong");
  chk_trace_state: assert property (
    @(posedge clk) disable iff (!reset_n)
    fresh_trace |=> rec_r.state_change && !rec_r.restartable)
    else $error("trace fault state flags wrong");
  chk_nontrace_first: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && !preret_hit && post_hit != 8'h00)
      |=> rec_r.ftype != `FCR_TYPE_TRACE ##1 trace_pending_r)
    else $error("trace not deferred behind fault");
  chk_irq_first: assert property (
    @(posedge clk) disable iff (!reset_n)
    (irq_req && !nontrace && !preret_hit)
      |=> irq_take_r && !rec_valid_r)
    else $error("interrupt not serviced first");
  chk_type_code: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && !vm_any && !preret_hit) |=>
      rec_r.ftype == `FCR_TYPE_TYPE && !rec_r.restartable &&
      rec_r.saved_ip == `FCR_ZERO32)
    else $error("bad type fault record");
  chk_type_sub: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && !vm_any && !preret_hit && type_mismatch)
      |=> rec_r.subtype == `FCR_SUB_TMIS)
    else $error("bad type mismatch subtype");
  chk_vm_ip: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && vm_any && !preret_hit) |=>
      rec_r.ftype == `FCR_TYPE_VMEM &&
      rec_r.saved_ip == $past(instr_ip))
    else $error("bad vm saved ip");
  chk_vm_page: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && !preret_hit && vm.page_invalid && !vm.seg_invalid &&
     !vm.dir_invalid) |=> rec_r.subtype == `FCR_SUB_PAGE &&
      rec_r.data0[31:`FCR_PAGE_LSB] == $past(vm.addr[31:`FCR_PAGE_LSB]))
    else $error("bad page entry record");
  chk_seg_index: assert property (
    @(posedge clk) disable iff (!reset_n)
    (nontrace && !preret_hit && vm.seg_invalid) |=>
      rec_r.subtype == `FCR_SUB_SEG &&
      rec_r.data1 == {$past(vm.seg_index), {`FCR_SEGIX_LSB{1'b0}}})
    else $error("bad segment entry record");
  chk_rec_whole: assert property (
    @(posedge clk) disable iff (!reset_n)
    rec_valid_r == (rec_r.ftype != `FCR_TYPE_NONE))
    else $error("record and strobe disagree");
  chk_resume_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    (valid_nxt && rec_nxt.resume) |=> resume_flag_r ##1
      (!$past(handler_ret) || do_resume_r))
    else $error("resume flag not set");
  chk_resume_ret: assert property (
    @(posedge clk) disable iff (!reset_n)
    do_resume_r |-> $past(handler_ret) && $past(resume_flag_r))
    else $error("resume without flag");

endmodule // fcr_unit

/* fcr_map.svh */
// Constant map for the fault classify and record unit
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH
`define FCR_TYPE_NONE   4'h0
`define FCR_TYPE_TRACE  4'h1
`define FCR_TYPE_VMEM   4'h6
`define FCR_TYPE_TYPE   4'hA
`define FCR_SUB_NONE    8'h00
`define FCR_SUB_TMIS    8'h01
`define FCR_SUB_CONT    8'h02
`define FCR_SUB_SEG     8'h01
`define FCR_SUB_DIR     8'h02
`define FCR_SUB_PAGE    8'h03
`define FCR_TB_INSTR    1
`define FCR_TB_BRANCH   2
`define FCR_TB_CALL     3
`define FCR_TB_RET      4
`define FCR_TB_PRERET   5
`define FCR_TB_SUPER    6
`define FCR_TB_BRKPT    7
`define FCR_TRACE_MASK  8'hFE
`define FCR_PAGE_LSB    12
`define FCR_SEGIX_LSB   5
`define FCR_ZERO32      32'h00000000
`endif

/* fcr_pkg.sv */
// Types shared by the fault classify and record unit
package fcr_pkg;
  typedef struct packed {
    logic [3:0]  ftype;
    logic [7:0]  subtype;
    logic [1:0]  flags;
    logic [31:0] data0;
    logic [31:0] data1;
    logic [31:0] fault_ip;
    logic [31:0] saved_ip;
    logic        state_change;
    logic        restartable;
    logic        resume;
  } fcr_record_t;

  typedef struct packed {
    logic        seg_invalid;
    logic        dir_invalid;
    logic        page_invalid;
    logic        large_seg;
    logic [31:0] addr;
    logic [26:0] seg_index;
    logic        suspend;
  } fcr_vm_t;

  typedef enum logic [1:0] {
    FCR_IDLE     = 2'b00,
    FCR_TRACE_PD = 2'b01
  } fcr_state_t;
endpackage

/* fcr_disp_model.sv */
// Handler dispatch model: returns from the handler after a set delay
`timescale 1ns/1ns

module fcr_disp_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rec_valid_r,
  input  wire logic [3:0] lat,
  output logic            handler_ret
);
  logic [3:0] cnt_r;

  // ==========================================================
  // Handler latency
  // Zero latency parks the handler, so no return ever comes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_r       <= 4'h0;
      handler_ret <= 1'b0;
    end else begin
      handler_ret <= (cnt_r == 4'h1);
      if (rec_valid_r && lat != 4'h0)
        cnt_r <= lat;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule // fcr_disp_model

/* fcr_unit_tb_top.sv */
// Self-checking testbench for the fault classify and record unit
`timescale 1ns/1ns

module fcr_unit_tb_top;
  logic                 clk = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 done = 1'b0, ten = 1'b0, irq = 1'b0, hret;
  logic                 tmis = 1'b0, tcon = 1'b0, seen;
  logic [31:0]          iip = 32'h00001000, nip = 32'h00001004;
  logic [7:0]           tmode = 8'h00, ev = 8'h00;
  logic [3:0]           lat = 4'h0, v;
  fcr_pkg::fcr_vm_t     vm = '0;
  fcr_pkg::fcr_record_t rec;
  logic                 rv, itake, rflag, dores, tpend;
  int                   fail_count = 0, checked = 0;
  localparam logic [31:0] Z = 32'h00000000;

  always #50 clk = ~clk;

  fcr_unit u_dut (.clk(clk), .reset_n(reset_n), .instr_done(done),
    .instr_ip(iip), .next_ip(nip), .trace_mode(tmode), .trace_enable(ten),
    .ev_instr(ev[1]), .ev_branch(ev[2]), .ev_call(ev[3]), .ev_ret(ev[4]),
    .ev_preret(ev[5]), .ev_super(ev[6]), .ev_brkpt(ev[7]),
    .type_mismatch(tmis), .type_contents(tcon), .vm(vm), .irq_req(irq),
    .handler_ret(hret), .rec_r(rec), .rec_valid_r(rv), .irq_take_r(itake),
    .resume_flag_r(rflag), .do_resume_r(dores), .trace_pending_r(tpend));

  fcr_disp_model u_disp (.clk(clk), .reset_n(reset_n), .rec_valid_r(rv),
    .lat(lat), .handler_ret(hret));

  // ==========================================================
  // Access and compare tasks
  task automatic tick;
    @(posedge clk);
    #10;
  endtask

  task automatic idle;
    done = 1'b0;
    ev = 8'h00;
    tmis = 1'b0;
    tcon = 1'b0;
    vm = '0;
    irq = 1'b0;
  endtask

  task automatic chk_bit(input logic a, input logic e, input string m);
    checked++;
    if (a !== e) begin
      fail_count++;
      $display("BAD t=%0t %s got %b want %b", $time, m, a, e);
    end
  endtask

  function automatic fcr_pkg::fcr_record_t mk(input logic [3:0] t,
    input logic [7:0] s, input logic [31:0] d0, d1, fi, si,
    input logic sc, rs, re);
    return {t, s, 2'b00, d0, d1, fi, si, sc, rs, re};
  endfunction

  // Mask picks which of state_change, restartable, resume are judged
  task automatic chk_rec(input fcr_pkg::fcr_record_t e, input logic [2:0] m);
    fcr_pkg::fcr_record_t a;
    a = rec;
    chk_bit(rv, 1'b1, "record strobe");
    if (!m[2]) {a.state_change, e.state_change} = 2'b00;
    if (!m[1]) {a.restartable, e.restartable} = 2'b00;
    if (!m[0]) {a.resume, e.resume} = 2'b00;
    checked++;
    if (a !== e) begin
      fail_count++;
      $display("BAD t=%0t record got %h want %h", $time, a, e);
    end
  endtask

  task automatic final_report;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, sized well above the ~55 cycles the tests need
  initial begin
    #(600 * 100);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    #10 reset_n = 1'b1;
    tick();
    chk_bit(rv, 1'b0, "idle after reset");
    ten = 1'b1;
    tmode = 8'hFE;
    done = 1'b1;
    for (int b = 1; b < 8; b++) begin
      ev = 8'h01 << b;
      tick();
      if (b == 5) chk_rec(mk(4'h1, 8'h20, Z, Z, Z, iip, 0, 1, 0), 3'b110);
      else chk_rec(mk(4'h1, ev, Z, Z, iip, nip, 1, 0, 0), 3'b100);
    end
    ev = 8'h04;
    tmode = 8'hFB;
    tick();
    chk_bit(rv, 1'b0, "masked mode bit");
    tmode = 8'hFE;
    ten = 1'b0;
    tick();
    chk_bit(rv, 1'b0, "trace disabled");
    ten = 1'b1;
    ev = 8'h8A;
    tick();
    chk_rec(mk(4'h1, 8'h8A, Z, Z, iip, nip, 1, 0, 0), 3'b100);
    ev = 8'h04;
    vm.dir_invalid = 1'b1;
    vm.addr = 32'hABCDE123;
    tick();
    idle();
    chk_rec(mk(4'h6, 8'h02, 32'hABCDE000, Z, iip, iip, 0, 0, 0), 3'b000);
    chk_bit(tpend, 1'b1, "trace deferred");
    tick();
    chk_rec(mk(4'h1, 8'h04, Z, Z, iip, nip, 1, 0, 0), 3'b100);
    done = 1'b1;
    vm.addr = 32'h12345678;
    vm.seg_index = 27'h5A5A5A5;
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 4'h8 : (k == 1) ? 4'h2 : (k == 2) ? 4'h3 : 4'hC;
      {vm.seg_invalid, vm.dir_invalid, vm.page_invalid, vm.large_seg} = v;
      tick();
      chk_rec(mk(4'h6, v[3] ? 8'h01 : v[2] ? 8'h02 : 8'h03,
        v[3] ? Z : 32'h12345000,
        (v[3] | (v[1] & v[0] & !v[2])) ? {vm.seg_index, 5'h00} : Z,
        iip, iip, 0, 0, 0), 3'b000);
    end
    vm = '0;
    for (int b = 1; b < 4; b++) begin
      {tcon, tmis} = b[1:0];
      tick();
      chk_rec(mk(4'hA, b[0] ? 8'h01 : 8'h02, Z, Z, iip, Z, 0, 0, 0),
        3'b010);
    end
    tmis = 1'b0;
    tcon = 1'b0;
    ev = 8'h02;
    irq = 1'b1;
    tick();
    done = 1'b0;
    ev = 8'h00;
    chk_bit(itake, 1'b1, "interrupt first");
    chk_bit(rv, 1'b0, "trace held back");
    tick();
    irq = 1'b0;
    chk_bit(itake, 1'b1, "interrupt again");
    tick();
    chk_rec(mk(4'h1, 8'h02, Z, Z, iip, nip, 1, 0, 0), 3'b100);
    done = 1'b1;
    ev = 8'h20;
    vm.page_invalid = 1'b1;
    irq = 1'b1;
    tick();
    idle();
    chk_rec(mk(4'h1, 8'h20, Z, Z, Z, iip, 0, 1, 0), 3'b110);
    chk_bit(itake, 1'b0, "prereturn ahead of interrupt");
    repeat (3) tick();
    lat = 4'h2;
    done = 1'b1;
    vm.page_invalid = 1'b1;
    vm.suspend = 1'b1;
    vm.addr = 32'h12345678;
    tick();
    idle();
    chk_rec(mk(4'h6, 8'h03, 32'h12345000, Z, iip, iip, 0, 0, 1),
      3'b001);
    chk_bit(rflag, 1'b1, "resume flag set");
    seen = 1'b0;
    for (int w = 0; w < 10 && !seen; w++) begin
      tick();
      seen = dores;
    end
    chk_bit(seen, 1'b1, "resume on return");
    repeat (2) tick();
    chk_bit(rflag, 1'b0, "resume flag cleared");
    final_report();
  end
endmodule // fcr_unit_tb_top
